/* jfc_cond_eval.sv */
// Condition test evaluator over the status flags
`timescale 1ns/1ps
module jfc_cond_eval
  import jfc_pkg::*;
(
  jfc_cond_if.eval ci
);
  typedef struct packed {
    logic pass;
    logic valid;
  } jfc_eval_t;
  jfc_eval_t r;
  logic c, v, z, n, u, e, nv, zo, nrm;
  always_comb begin
    c   = ci.flags[SR_C];
    v   = ci.flags[SR_V];
    z   = ci.flags[SR_Z];
    n   = ci.flags[SR_N];
    u   = ci.flags[SR_U];
    e   = ci.flags[SR_E];
    nv  = n ^ v;
    zo  = z | nv;
    nrm = z | (~u & ~e);
    r   = '{pass: 1'b0, valid: 1'b1};
    case (jfc_cond_t'(ci.code))
      CND_CARRY_CLEAR:      r.pass = ~c;  // [RULE3]
      CND_CARRY_SET:        r.pass = c;   // [RULE3]
      CND_EQUAL:            r.pass = z;   // [RULE4]
      CND_NOT_EQUAL:        r.pass = ~z;  // [RULE4]
      CND_GREATER_OR_EQUAL: r.pass = ~nv; // [RULE4]
      CND_LESS_THAN:        r.pass = nv;  // [RULE4]
      CND_GREATER_THAN:     r.pass = ~zo; // [RULE5]
      CND_LESS_OR_EQUAL:    r.pass = zo;  // [RULE5]
      CND_NOT_NORMALIZED:   r.pass = ~nrm; // [RULE5]
      CND_NORMALIZED:       r.pass = nrm; // [RULE5]
      CND_HIGHER_OR_SAME: begin
        r.pass  = ~c;          // [RULE3]
        r.valid = ci.cc_mode;  // [RULE6]
      end
      CND_LOWER: begin
        r.pass  = c;           // [RULE3]
        r.valid = ci.cc_mode;  // [RULE6]
      end
      default:              r.valid = 1'b0;
    endcase
  end
  assign ci.pass  = r.pass;
  assign ci.valid = r.valid;
endmodule

/* jfc_cond_if.sv */
// Condition evaluation signals between the sequencer and the evaluator
`timescale 1ns/1ps
interface jfc_cond_if;
  logic [3:0] code;
  logic [5:0] flags;
  logic       cc_mode;
  logic       pass;
  logic       valid;
  modport core (output code, output flags, output cc_mode, input pass, input valid);
  modport eval (input code, input flags, input cc_mode, output pass, output valid);
endinterface

/* jfc_core.sv */
// Jump flow control sequencer with APB register access
// Operation
// RULE1: Taken conditional jump loads 16-bit target
// RULE2: Untaken conditional jump advances PC sequentially
// RULE3: Carry clear passes C=0, set C=1
// RULE4: Equal/not-equal on Z; GE/LT on N^V
// RULE5: GT/LE on Z|(N^V); normalization tests
// RULE6: Alias tests only with mode bit set
// RULE7: Conditional jump leaves flags unchanged
// RULE8: Conditional jump: two words, 6/4 cycles
// RULE9: Software avoids conditional jump near loop end
// RULE10: Software never repeats jump instructions
// RULE11: Unconditional jump always loads 16-bit target
// RULE12: Unconditional jump: two words, 6 cycles
// RULE13: Software avoids jump/call at loop end
// RULE14: Call pushes PC, then status, then jumps
// RULE15: Call: two words, 8 cycles
// RULE16: Call target never the loop end
// RULE17: Jump and call leave flags unchanged
// RULE18: PC and targets are 16 bits wide
// RULE19: Return address follows two-word call
`timescale 1ns/1ps
module jfc_core
  import jfc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [15:0] pc_value,
  output logic             stk_we,
  output logic      [15:0] stk_addr,
  output logic      [15:0] stk_wdata,
  output logic             busy,
  output logic             done
);
  typedef struct packed {
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
    logic [ADDR_W-1:0]     pc;
    logic [ADDR_W-1:0]     sp;
    logic [15:0]           sr;
    logic                  cc_mode;
    logic [JX_W-1:0]       extra;
    logic [ADDR_W-1:0]     target;
    jfc_op_t               op;
    logic [3:0]            cond;
    jfc_state_t            state;
    logic [CNT_W-1:0]      cnt;
    logic [CNT_W-1:0]      total;
    logic                  taken;
    logic                  rejected;
    logic                  done;
    logic                  stk_we;
    logic [ADDR_W-1:0]     stk_addr;
    logic [15:0]           stk_wdata;
  } jfc_core_t;

  jfc_core_t q;
  jfc_core_t d;

  jfc_cond_if ci ();
  jfc_cond_eval u_eval (.ci(ci));

  logic              setup;
  logic              access;
  logic              wr;
  logic              go;
  logic              run_taken;
  logic [CNT_W-1:0]  base;
  logic [ADDR_W-1:0] ret_addr;
  logic [ADDR_W-1:0] next_pc;
  logic              hit;
  logic [31:0]       rdata;
  jfc_op_t           wop;

  assign ci.code    = pwdata[CTRL_COND_LSB +: 4];
  assign ci.flags   = q.sr[SR_E:SR_C];
  assign ci.cc_mode = q.cc_mode;

  always_comb begin
    setup    = psel & ~penable;
    access   = psel & penable & q.pready;
    wr       = access & pwrite;
    wop      = jfc_op_t'(pwdata[CTRL_OP_LSB +: 2]);
    go       = wr & (paddr == OFS_CTRL) & pwdata[CTRL_GO_BIT];
    ret_addr = q.pc + INSTR_WORDS; // [RULE19]
    next_pc  = q.pc + INSTR_WORDS; // [RULE2] [RULE8]
    run_taken = 1'b0;
    base      = CYC_JUMP;
    case (wop)
      OP_COND_JUMP: begin
        run_taken = ci.pass;
        base = ci.pass ? CYC_JCC_TAKEN : CYC_JCC_NOT; // [RULE8]
      end
      OP_UNCONDITIONAL_JUMP: begin
        run_taken = 1'b1; // [RULE11]
        base = CYC_JUMP;  // [RULE12]
      end
      OP_CALL_SUBROUTINE: begin
        run_taken = 1'b1;
        base = CYC_CALL;  // [RULE15]
      end
      default: begin
        run_taken = 1'b0;
        base = CYC_JUMP;
      end
    endcase
  end

  // Register read mux, sampled in the setup cycle
  always_comb begin
    hit   = 1'b1;
    rdata = '0;
    case (paddr)
      OFS_CTRL: begin
        rdata[CTRL_OP_LSB +: 2]   = q.op;
        rdata[CTRL_COND_LSB +: 4] = q.cond;
      end
      OFS_TARGET: rdata[ADDR_W-1:0] = q.target;
      OFS_PC:     rdata[ADDR_W-1:0] = q.pc;
      OFS_SP:     rdata[ADDR_W-1:0] = q.sp;
      OFS_SR:     rdata[15:0] = q.sr;
      OFS_OMR:    rdata[OMR_CC_BIT] = q.cc_mode;
      OFS_EXTRA:  rdata[JX_W-1:0] = q.extra;
      OFS_STATUS: begin
        rdata[ST_BUSY]  = (q.state == ST_RUN);
        rdata[ST_TAKEN] = q.taken;
        rdata[ST_REJ]   = q.rejected;
        rdata[ST_CNT +: CNT_W] = q.total;
      end
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    d         = q;
    d.pready  = setup;
    d.done    = 1'b0;
    d.stk_we  = 1'b0;
    if (setup) begin
      d.prdata  = pwrite ? '0 : rdata;
      d.pslverr = ~hit | (pwrite & (q.state == ST_RUN) & (paddr != OFS_EXTRA)
                  & (paddr != OFS_OMR));
    end

    // Target/PC/SP/SR writes only while idle; OMR and extra writes land even during a run
    if (wr && q.state == ST_IDLE) begin
      case (paddr)
        OFS_TARGET: d.target = pwdata[ADDR_W-1:0]; // [RULE18]
        OFS_PC:     d.pc     = pwdata[ADDR_W-1:0]; // [RULE18]
        OFS_SP:     d.sp     = pwdata[ADDR_W-1:0];
        OFS_SR:     d.sr     = pwdata[15:0];
        default: begin
        end
      endcase
    end
    if (wr && paddr == OFS_OMR) begin
      d.cc_mode = pwdata[OMR_CC_BIT];
    end
    if (wr && paddr == OFS_EXTRA) begin
      d.extra = pwdata[JX_W-1:0];
    end

    case (q.state)
      ST_IDLE: begin
        if (go) begin
          d.op   = wop;
          d.cond = pwdata[CTRL_COND_LSB +: 4];
          if ((wop == OP_COND_JUMP && !ci.valid) || wop == OP_RESERVED) begin
            d.rejected = 1'b1; // [RULE6]
            d.taken    = 1'b0;
            d.done     = 1'b1;
          end else begin
            d.rejected = 1'b0;
            d.taken    = run_taken;
            d.total    = base + CNT_W'(q.extra);
            d.cnt      = CNT_W'(1);
            d.state    = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        // Two-step stack push of return address then status
        if (q.op == OP_CALL_SUBROUTINE) begin
          if (q.cnt == CYC_PUSH_PC) begin
            d.sp        = q.sp + 16'h0001; // [RULE14]
            d.stk_we    = 1'b1;
            d.stk_addr  = q.sp + 16'h0001;
            d.stk_wdata = ret_addr;        // [RULE14] [RULE19]
          end else if (q.cnt == CYC_PUSH_SR) begin
            d.sp        = q.sp + 16'h0001; // [RULE14]
            d.stk_we    = 1'b1;
            d.stk_addr  = q.sp + 16'h0001;
            d.stk_wdata = q.sr;            // [RULE14]
          end
        end
        if (q.cnt == q.total) begin
          // Status flags are never written by a jump [RULE7] [RULE17]
          if (q.taken) begin
            d.pc = q.target; // [RULE1] [RULE11] [RULE14]
          end else begin
            d.pc = next_pc;  // [RULE2]
          end
          d.state = ST_IDLE;
          d.done  = 1'b1;
        end else begin
          d.cnt = q.cnt + CNT_W'(1);
        end
      end
      default: d.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.pready    <= 1'b0;
      q.pslverr   <= 1'b0;
      q.prdata    <= 32'h0000_0000;
      q.pc        <= PC_RST;
      q.sp        <= SP_RST;
      q.sr        <= SR_RST;
      q.cc_mode   <= 1'b0;
      q.extra     <= '0;
      q.target    <= 16'h0000;
      q.op        <= OP_COND_JUMP;
      q.cond      <= 4'h0;
      q.state     <= ST_IDLE;
      q.cnt       <= '0;
      q.total     <= '0;
      q.taken     <= 1'b0;
      q.rejected  <= 1'b0;
      q.done      <= 1'b0;
      q.stk_we    <= 1'b0;
      q.stk_addr  <= 16'h0000;
      q.stk_wdata <= 16'h0000;
    end else begin
      q <= d;
    end
  end

  assign prdata    = q.prdata;
  assign pready    = q.pready;
  assign pslverr   = q.pslverr;
  assign pc_value  = q.pc;
  assign stk_we    = q.stk_we;
  assign stk_addr  = q.stk_addr;
  assign stk_wdata = q.stk_wdata;
  assign busy      = (q.state == ST_RUN);
  assign done      = q.done;
endmodule

/* jfc_core_props.sv */
// Concurrent checks on the jump flow control core ports
`timescale 1ns/1ps
module jfc_core_props (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic [15:0] pc_value,
  input logic        stk_we,
  input logic [15:0] stk_addr,
  input logic [15:0] stk_wdata,
  input logic        busy,
  input logic        done
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  busy_min_a: assert property ($rose(busy) |-> busy[*4])
    else $error("run shorter than four cycles");
  done_end_a: assert property ($fell(busy) |-> done)
    else $error("run ended without done");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
  pc_hold_a: assert property (busy |-> $stable(pc_value))
    else $error("pc moved during a run");
  pc_cause_a: assert property ($changed(pc_value) |->
    done || $past(psel && penable && pwrite && pready)) else $error("pc moved without cause");
  push_data_a: assert property ($rose(stk_we) |-> stk_wdata == pc_value + 16'h0002)
    else $error("return address wrong");
  push_pair_a: assert property ($rose(stk_we) |=>
    stk_we && stk_addr == $past(stk_addr) + 16'h0001 ##1 !stk_we) else $error("push pair wrong");
  call_len_a: assert property ($rose(stk_we) |-> busy[*7])
    else $error("call shorter than eight cycles");
  stk_in_run_a: assert property (stk_we |-> busy)
    else $error("stack write outside a run");
  cover property ($fell(busy) && done);
  cover property ($rose(stk_we));
  cover property (pready && pslverr);
endmodule
bind jfc_core jfc_core_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .pc_value, .stk_we, .stk_addr, .stk_wdata, .busy, .done);

/* jfc_pkg.sv */
// Shared constants and types for the jump flow control block
package jfc_pkg;
  localparam int ADDR_W = 16;
  localparam int CNT_W  = 5;
  localparam int JX_W   = 4;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_TARGET = 8'h04;
  localparam logic [7:0] OFS_PC     = 8'h08;
  localparam logic [7:0] OFS_SP     = 8'h0C;
  localparam logic [7:0] OFS_SR     = 8'h10;
  localparam logic [7:0] OFS_OMR    = 8'h14;
  localparam logic [7:0] OFS_EXTRA  = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  // Control register fields
  localparam int CTRL_OP_LSB   = 0;
  localparam int CTRL_COND_LSB = 4;
  localparam int CTRL_GO_BIT   = 8;
  // Operating mode register: condition-code mode bit
  localparam int OMR_CC_BIT    = 8;
  // Status register flag positions
  localparam int SR_C = 0;
  localparam int SR_V = 1;
  localparam int SR_Z = 2;
  localparam int SR_N = 3;
  localparam int SR_U = 4;
  localparam int SR_E = 5;
  // Status readout fields
  localparam int ST_BUSY  = 0;
  localparam int ST_TAKEN = 1;
  localparam int ST_REJ   = 2;
  localparam int ST_CNT   = 8;
  // Reset values
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [15:0] SR_RST = 16'h0000;
  // Instruction length in program words
  localparam logic [15:0] INSTR_WORDS = 16'h0002;
  // Base cycle counts and the run cycles of the two call pushes
  localparam logic [CNT_W-1:0] CYC_JCC_TAKEN = 5'd6;
  localparam logic [CNT_W-1:0] CYC_JCC_NOT   = 5'd4;
  localparam logic [CNT_W-1:0] CYC_JUMP      = 5'd6;
  localparam logic [CNT_W-1:0] CYC_CALL      = 5'd8;
  localparam logic [CNT_W-1:0] CYC_PUSH_PC   = 5'd1;
  localparam logic [CNT_W-1:0] CYC_PUSH_SR   = 5'd2;
  typedef enum logic [1:0] {
    OP_COND_JUMP,
    OP_UNCONDITIONAL_JUMP,
    OP_CALL_SUBROUTINE,
    OP_RESERVED
  } jfc_op_t;
  typedef enum logic [3:0] {
    CND_CARRY_CLEAR,
    CND_CARRY_SET,
    CND_EQUAL,
    CND_GREATER_OR_EQUAL,
    CND_GREATER_THAN,
    CND_LESS_OR_EQUAL,
    CND_LESS_THAN,
    CND_NOT_EQUAL,
    CND_NOT_NORMALIZED,
    CND_NORMALIZED,
    CND_HIGHER_OR_SAME,
    CND_LOWER,
    CND_RSV_C,
    CND_RSV_D,
    CND_RSV_E,
    CND_RSV_F
  } jfc_cond_t;
  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } jfc_state_t;
endpackage

/* jfc_stack_mem.sv */
// Data memory model holding the stack words pushed by a call
`timescale 1ns/1ps
module jfc_stack_mem (
  input  logic        pclk,
  input  logic        stk_we,
  input  logic [15:0] stk_addr,
  input  logic [15:0] stk_wdata,
  input  logic [15:0] rd_addr,
  output logic [15:0] rd_data
);
  logic [15:0] mem [0:15];
  // Words land at the edge where the strobe is seen; unwritten words read unknown
  always_ff @(posedge pclk) begin
    if (stk_we) begin
      mem[stk_addr[3:0]] <= stk_wdata;
    end
  end
  assign rd_data = mem[rd_addr[3:0]];
endmodule

/* test_jump_flow_control.sv */
// Self-checking bench for the jump flow control core
`timescale 1ns/1ps
module test_jump_flow_control;
  import jfc_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, stk_we, busy, done, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pc_value, stk_addr, stk_wdata, ra, rdat;
  logic [5:0]  fl [8] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h0A, 6'h10, 6'h20};
  int          error_cnt, checked, cyc;
  jfc_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pc_value, .stk_we, .stk_addr, .stk_wdata, .busy, .done);
  jfc_stack_mem mem (.pclk, .stk_we, .stk_addr, .stk_wdata, .rd_addr(ra), .rd_data(rdat));
  always #2.5 pclk = ~pclk;
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One APB transfer; starts at the next edge and releases at the pready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string s);
    apb(1'b0, a, 32'h0, rd, er);
    chk(s, rd, x);
  endtask
  // Launch one instruction and count its busy cycles up to done
  // Each jump runs once and never sits at a loop end
  task automatic run(input logic [1:0] op, input logic [3:0] cd, input int t, input logic rj);
    wr(OFS_CTRL, {23'h0, 1'h1, cd, 2'h0, op});
    cyc = 0;
    repeat (40) begin
      #1;
      if (done === 1'b1) break;
      if (busy === 1'b1) cyc++;
      @(posedge pclk);
    end
    chk("cycles", cyc, t);
    apb(1'b0, OFS_STATUS, 32'h0, rd, er);
    chk("rejected", {31'h0, rd[ST_REJ]}, {31'h0, rj});
    chk("idle", {31'h0, rd[ST_BUSY]}, 32'h0);
    if (!rj) chk("total", {27'h0, rd[ST_CNT +: CNT_W]}, 32'(t));
  endtask
  function automatic logic cpass(input logic [3:0] c, input logic [5:0] f);
    logic nv;
    nv = f[SR_N] ^ f[SR_V];
    case (c)
      4'h0, 4'hA: return !f[SR_C];
      4'h1, 4'hB: return f[SR_C];
      4'h2: return f[SR_Z];
      4'h3: return !nv;
      4'h4: return !(f[SR_Z] | nv);
      4'h5: return f[SR_Z] | nv;
      4'h6: return nv;
      4'h7: return !f[SR_Z];
      4'h8: return !(f[SR_Z] | (!f[SR_U] & !f[SR_E]));
      default: return f[SR_Z] | (!f[SR_U] & !f[SR_E]);
    endcase
  endfunction
  task automatic t_conds();
    logic p;
    wr(OFS_TARGET, 32'h0000_4321);
    for (int i = 0; i < 8; i++) begin
      for (int c = 0; c < 10; c++) begin
        p = cpass(4'(c), fl[i]);
        wr(OFS_PC, 32'h0000_0100);
        wr(OFS_SR, {26'h0, fl[i]});
        run(2'h0, 4'(c), p ? 6 : 4, 1'b0);
        rdc(OFS_PC, p ? 32'h0000_4321 : 32'h0000_0102, "pc cond");
        rdc(OFS_SR, {26'h0, fl[i]}, "sr kept");
      end
    end
    $display("t_conds done");
  endtask
  task automatic t_alias();
    logic ok, tk;
    for (int m = 0; m < 2; m++) begin
      wr(OFS_OMR, m ? 32'h0000_0100 : 32'h0);
      wr(OFS_SR, 32'h0000_0001);
      for (int c = 10; c < 13; c++) begin
        ok = m && c < 12;
        tk = ok && c == 11;
        wr(OFS_PC, 32'h0000_0200);
        run(2'h0, 4'(c), ok ? (tk ? 6 : 4) : 0, !ok);
        rdc(OFS_PC, tk ? 32'h0000_4321 : ok ? 32'h0000_0202 : 32'h0000_0200, "pc alias");
      end
    end
    run(2'h3, 4'h0, 0, 1'b1);
    wr(OFS_OMR, 32'h0);
    $display("t_alias done");
  endtask
  task automatic t_jump();
    wr(OFS_EXTRA, 32'h0000_0003);
    wr(OFS_TARGET, 32'h0000_FFFE);
    wr(OFS_SR, 32'h0000_003F);
    run(2'h1, 4'h0, 9, 1'b0);
    rdc(OFS_PC, 32'h0000_FFFE, "pc jump");
    run(2'h0, 4'h7, 7, 1'b0);
    rdc(OFS_PC, 32'h0000_0000, "pc wrap");
    rdc(OFS_SR, 32'h0000_003F, "sr jump");
    wr(OFS_EXTRA, 32'h0);
    $display("t_jump done");
  endtask
  task automatic t_call();
    wr(OFS_SP, 32'h0000_0010);
    wr(OFS_PC, 32'h0000_1234);
    wr(OFS_SR, 32'h0000_002A);
    wr(OFS_TARGET, 32'h0000_0ABC); // Target is no loop end
    run(2'h2, 4'h0, 8, 1'b0);
    rdc(OFS_PC, 32'h0000_0ABC, "pc call");
    chk("pc pin", {16'h0, pc_value}, 32'h0000_0ABC);
    rdc(OFS_SP, 32'h0000_0012, "sp call");
    rdc(OFS_SR, 32'h0000_002A, "sr call");
    ra = 16'h0011;
    #1 chk("ret addr", {16'h0, rdat}, 32'h0000_1236);
    ra = 16'h0012;
    #1 chk("saved sr", {16'h0, rdat}, 32'h0000_002A);
    $display("t_call done");
  endtask
  task automatic t_refuse();
    wr(OFS_TARGET, 32'h0000_0777);
    wr(OFS_CTRL, 32'h0000_0101);
    apb(1'b1, OFS_PC, 32'h0000_5555, rd, er);
    chk("busy pc write", {31'h0, er}, 32'h1);
    repeat (12) @(posedge pclk);
    rdc(OFS_PC, 32'h0000_0777, "pc after jump");
    apb(1'b0, 8'h20, 32'h0, rd, er);
    chk("unmapped err", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("t_refuse done");
  endtask
  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    ra = '0;
    error_cnt = 0;
    checked = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc(OFS_PC, 32'h0, "pc reset");
    t_conds();
    t_alias();
    t_jump();
    t_call();
    t_refuse();
    end_of_test();
  end
endmodule
